// ### rtl/scb_defines.svh
// Register offsets, field positions and reset values of the scaler bank
// Assumes word-indexed register addresses on a plain register port
`ifndef SCB_DEFINES_SVH
`define SCB_DEFINES_SVH
`define SCB_ADDR_W          6
`define SCB_OFF_PWR_GATE    6'h00
`define SCB_OFF_CTRL        6'h01
`define SCB_OFF_WIN_POS     6'h02
`define SCB_OFF_WIN_SIZE    6'h03
`define SCB_OFF_VPHASE      6'h04
`define SCB_OFF_HPHASE      6'h05
`define SCB_OFF_ADAPT       6'h06
`define SCB_OFF_COEF0_IDX   6'h08
`define SCB_OFF_COEF0_DATA  6'h09
`define SCB_OFF_COEF1_IDX   6'h0a
`define SCB_OFF_COEF1_DATA  6'h0b
`define SCB_OFF_STATUS      6'h0c
`define SCB_CTRL_ALLOW_BIT  0
`define SCB_CTRL_HSEL_BIT   1
`define SCB_CTRL_VSEL_BIT   2
`define SCB_CTRL_YSEL_BIT   3
`define SCB_CTRL_UVSEL_BIT  4
`define SCB_CTRL_PROG_BIT   5
`define SCB_COEF_WORDS      60
`define SCB_COEF_LAST       6'h3b
`define SCB_COEF_IDX_W      6
`define SCB_RESV_MASK       32'h0000ffff
`define SCB_RST_REG         32'h0000_0000
`endif

// ### rtl/scb_pkg.sv
// Types shared by the scaler coefficient and double-buffer bank
// Assumes scb_defines.svh is on the include path
package scb_pkg;
    typedef struct packed {
        logic [5:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } scb_bus_req_t;

    typedef struct packed {
        logic        vblank;
        logic        frame_start;
        logic        pipe_en;
    } scb_timing_t;

    typedef struct packed {
        logic [31:0] pwr_gate;
        logic [31:0] ctrl;
    } scb_ctrl_grp_t;

    typedef struct packed {
        logic [31:0] win_pos;
        logic [31:0] win_size;
        logic [31:0] vphase;
        logic [31:0] hphase;
        logic [31:0] adapt;
    } scb_win_grp_t;
endpackage

// ### rtl/scb_coef_set.sv
// One programmable coefficient set with pending and active copies
// Assumes synchronous word-indexed access from the bank
`timescale 1ns/1ns
`include "scb_defines.svh"
module scb_coef_set
    import scb_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        idx_wr,
    input  wire logic        data_wr,
    input  wire logic [31:0] wdata,
    input  wire logic        commit,
    input  wire logic [5:0]  rd_sel,
    output logic      [5:0]  idx_q,
    output logic      [31:0] rdata,
    output logic      [31:0] act_word
);
    logic [31:0] pend_q [`SCB_COEF_WORDS];
    logic [31:0] act_q  [`SCB_COEF_WORDS];

    // Index register selects the packed word
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            idx_q <= '0;
        else if (ce && idx_wr)
            idx_q <= wdata[5:0];
    end

    // Pending store, upper half of the last word kept zero
    always_ff @(posedge sys_clk)
    begin
        if (ce && data_wr && idx_q <= `SCB_COEF_LAST)
        begin
            if (idx_q == `SCB_COEF_LAST)
                pend_q[idx_q] <= wdata & `SCB_RESV_MASK;
            else
                pend_q[idx_q] <= wdata;
        end
    end

    // Active copy loaded at the control group trigger
    always_ff @(posedge sys_clk)
    begin
        if (ce && commit)
            act_q <= pend_q;
    end

    assign rdata    = (idx_q <= `SCB_COEF_LAST) ? pend_q[idx_q] : '0;
    assign act_word = (rd_sel <= `SCB_COEF_LAST) ? act_q[rd_sel] : '0;
endmodule

// ### rtl/scb_arm_ctl.sv
// Double-buffer arming and group trigger generation
// Assumes timing events are one-cycle synchronous pulses or levels
`timescale 1ns/1ns
module scb_arm_ctl
    import scb_pkg::*;
#(
    parameter bit NEWER_GEN = 1'b1
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire scb_timing_t tim,
    input  wire logic        ctrl_wr,
    input  wire logic        winsz_wr,
    input  wire logic        allow_upd,
    output logic             ctrl_trig,
    output logic             win_trig,
    output logic             armed_q
);
    logic vblank_q;
    logic vb_rise;
    logic old_ctrl;
    logic old_win;
    logic new_trig;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            vblank_q <= 1'b0;
        else if (ce)
            vblank_q <= tim.vblank;
    end

    assign vb_rise  = tim.vblank && !vblank_q;
    assign old_ctrl = tim.pipe_en && armed_q && vb_rise;
    assign old_win  = tim.pipe_en && armed_q && tim.frame_start;
    assign new_trig = tim.pipe_en && armed_q && vb_rise
                      && allow_upd;

    // Generation select, pipe-off writes trigger at once
    always_comb
    begin
        if (NEWER_GEN)
        begin
            ctrl_trig = (!tim.pipe_en && ctrl_wr) || new_trig;
            win_trig  = (!tim.pipe_en && winsz_wr) || new_trig;
        end
        else
        begin
            ctrl_trig = (!tim.pipe_en && ctrl_wr) || old_ctrl;
            win_trig  = (!tim.pipe_en && winsz_wr) || old_win;
        end
    end

    // Arm on pipe-on window-size write; the new write wins over disarm
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            armed_q <= 1'b0;
        else if (ce)
        begin
            if (tim.pipe_en && winsz_wr)
                armed_q <= 1'b1;
            else if (NEWER_GEN ? new_trig : old_win)
                armed_q <= 1'b0;
        end
    end
endmodule

// ### rtl/scb_bank.sv
// Scaler register bank: coefficient sets and double-buffered registers
// Assumes a plain register port and pipe timing on sys_clk
//
// Function
// - Two coefficient sets, filters select independently
// - Luma and chroma pick sets independently
// - Each set has index and data registers
// - Sixty packed words of seventeen seven-tap phases
// - Phase-major order, low half first, 3Bh top reserved
// - Pipe off: control write triggers control group
// - Pipe off: window-size write triggers window group
// - Older: control group loads on vblank rise
// - Older: window group loads after frame start
// - Newer: vblank rise loads when armed, allowed
// - Pipe on: window-size write arms buffering
// - Older: disarm at next window group trigger
// - Newer: disarm at allowed vblank rise
// - Registers split into control and window groups
// - Coefficient sets belong to control group
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "scb_defines.svh"
module scb_bank
    import scb_pkg::*;
#(
    parameter bit NEWER_GEN = 1'b1
)
(
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire scb_bus_req_t  bus,
    input  wire scb_timing_t   tim,
    input  wire logic [5:0]    coef_rd_idx,
    output logic      [31:0]   rdata_q,
    output scb_ctrl_grp_t      act_ctrl_q,
    output scb_win_grp_t       act_win_q,
    output logic               hsel_q,
    output logic               vsel_q,
    output logic               ysel_q,
    output logic               uvsel_q,
    output logic [31:0]        coef0_word_q,
    output logic [31:0]        coef1_word_q,
    output logic               armed_out_q
);
    scb_ctrl_grp_t pend_ctrl_q;
    scb_win_grp_t  pend_win_q;
    logic          wr;
    logic          ctrl_wr;
    logic          winsz_wr;
    logic          ctrl_trig;
    logic          win_trig;
    logic          armed;
    logic [1:0]    idx_wr;
    logic [1:0]    data_wr;
    logic [5:0]    idx [2];
    logic [31:0]   crd [2];
    logic [31:0]   cact [2];
    logic [31:0]   rd_d;

    assign wr       = ce && bus.wr;
    assign ctrl_wr  = wr && bus.addr == `SCB_OFF_CTRL;
    assign winsz_wr = wr && bus.addr == `SCB_OFF_WIN_SIZE;

    scb_arm_ctl #(.NEWER_GEN(NEWER_GEN)) u_arm
    (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .tim       (tim),
        .ctrl_wr   (ctrl_wr),
        .winsz_wr  (winsz_wr),
        .allow_upd (act_ctrl_q.ctrl[`SCB_CTRL_ALLOW_BIT]),
        .ctrl_trig (ctrl_trig),
        .win_trig  (win_trig),
        .armed_q   (armed)
    );

    // Two independent coefficient sets
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_set
            assign idx_wr[g]  = wr && bus.addr ==
                (g == 0 ? `SCB_OFF_COEF0_IDX : `SCB_OFF_COEF1_IDX);
            assign data_wr[g] = wr && bus.addr ==
                (g == 0 ? `SCB_OFF_COEF0_DATA : `SCB_OFF_COEF1_DATA);
            scb_coef_set u_set
            (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .ce       (ce),
                .idx_wr   (idx_wr[g]),
                .data_wr  (data_wr[g]),
                .wdata    (bus.wdata),
                .commit   (ctrl_trig),
                .rd_sel   (coef_rd_idx),
                .idx_q    (idx[g]),
                .rdata    (crd[g]),
                .act_word (cact[g])
            );
        end
    endgenerate

    // Control group pending copies
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pend_ctrl_q <= '0;
        else if (wr)
        begin
            if (bus.addr == `SCB_OFF_PWR_GATE)
                pend_ctrl_q.pwr_gate <= bus.wdata;
            if (bus.addr == `SCB_OFF_CTRL)
                pend_ctrl_q.ctrl <= bus.wdata;
        end
    end

    // Window group pending copies
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pend_win_q <= '0;
        else if (wr)
        begin
            unique case (bus.addr)
                `SCB_OFF_WIN_POS:  pend_win_q.win_pos  <= bus.wdata;
                `SCB_OFF_WIN_SIZE: pend_win_q.win_size <= bus.wdata;
                `SCB_OFF_VPHASE:   pend_win_q.vphase   <= bus.wdata;
                `SCB_OFF_HPHASE:   pend_win_q.hphase   <= bus.wdata;
                `SCB_OFF_ADAPT:    pend_win_q.adapt    <= bus.wdata;
                default:           pend_win_q <= pend_win_q;
            endcase
        end
    end

    // Control group active copy; same-cycle control write is taken directly
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            act_ctrl_q <= '0;
        else if (ce && ctrl_trig)
        begin
            act_ctrl_q <= pend_ctrl_q;
            if (ctrl_wr)
                act_ctrl_q.ctrl <= bus.wdata;
        end
    end

    // Window group active copy
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            act_win_q <= '0;
        else if (ce && win_trig)
        begin
            act_win_q <= pend_win_q;
            if (winsz_wr)
                act_win_q.win_size <= bus.wdata;
        end
    end

    // Filter and plane set selects from the active control word
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hsel_q  <= 1'b0;
            vsel_q  <= 1'b0;
            ysel_q  <= 1'b0;
            uvsel_q <= 1'b0;
        end
        else if (ce)
        begin
            hsel_q  <= act_ctrl_q.ctrl[`SCB_CTRL_HSEL_BIT];
            vsel_q  <= act_ctrl_q.ctrl[`SCB_CTRL_VSEL_BIT];
            ysel_q  <= act_ctrl_q.ctrl[`SCB_CTRL_YSEL_BIT];
            uvsel_q <= act_ctrl_q.ctrl[`SCB_CTRL_UVSEL_BIT];
        end
    end

    // Active coefficient words for the filter
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            coef0_word_q <= '0;
            coef1_word_q <= '0;
            armed_out_q  <= 1'b0;
        end
        else if (ce)
        begin
            coef0_word_q <= cact[0];
            coef1_word_q <= cact[1];
            armed_out_q  <= armed;
        end
    end

    // Read mux returns pending copies
    always_comb
    begin
        rd_d = '0;
        unique case (bus.addr)
            `SCB_OFF_PWR_GATE:   rd_d = pend_ctrl_q.pwr_gate;
            `SCB_OFF_CTRL:       rd_d = pend_ctrl_q.ctrl;
            `SCB_OFF_WIN_POS:    rd_d = pend_win_q.win_pos;
            `SCB_OFF_WIN_SIZE:   rd_d = pend_win_q.win_size;
            `SCB_OFF_VPHASE:     rd_d = pend_win_q.vphase;
            `SCB_OFF_HPHASE:     rd_d = pend_win_q.hphase;
            `SCB_OFF_ADAPT:      rd_d = pend_win_q.adapt;
            `SCB_OFF_COEF0_IDX:  rd_d = {26'h0, idx[0]};
            `SCB_OFF_COEF0_DATA: rd_d = crd[0];
            `SCB_OFF_COEF1_IDX:  rd_d = {26'h0, idx[1]};
            `SCB_OFF_COEF1_DATA: rd_d = crd[1];
            `SCB_OFF_STATUS:     rd_d = {30'h0, tim.pipe_en, armed};
            default:             rd_d = '0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rdata_q <= '0;
        else if (ce)
            rdata_q <= (bus.rd) ? rd_d : '0;
    end
endmodule

// ### verif/scb_bank_chk.sv
// Port assertions for the scaler register bank
// Assumes a bind to every scb_bank instance, one clock domain
`timescale 1ns/1ns
`include "scb_defines.svh"
module scb_bank_chk
    import scb_pkg::*;
#(
    parameter bit NEWER_GEN = 1'b1
)
(
    input wire logic          sys_clk,
    input wire logic          rst,
    input wire logic          ce,
    input wire scb_bus_req_t  bus,
    input wire scb_timing_t   tim,
    input wire logic [5:0]    coef_rd_idx,
    input wire logic [31:0]   rdata_q,
    input wire scb_ctrl_grp_t act_ctrl_q,
    input wire scb_win_grp_t  act_win_q,
    input wire logic          hsel_q,
    input wire logic          vsel_q,
    input wire logic          ysel_q,
    input wire logic          uvsel_q,
    input wire logic [31:0]   coef0_word_q,
    input wire logic [31:0]   coef1_word_q,
    input wire logic          armed_out_q
);
    logic       vb_q;
    logic       vb_rise;
    logic       wsz_wr;
    logic [3:0] sel_src;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            vb_q <= 1'b0;
        else if (ce)
            vb_q <= tim.vblank;
    end
    assign vb_rise = tim.vblank & ~vb_q;
    assign wsz_wr  = ce & bus.wr & (bus.addr == `SCB_OFF_WIN_SIZE);
    assign sel_src = act_ctrl_q.ctrl[4:1];
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence s_arm;
        wsz_wr && tim.pipe_en ##1 !tim.vblank && !tim.frame_start;
    endsequence
    sequence s_disarm;
        tim.pipe_en && !wsz_wr && (NEWER_GEN ?
            (vb_rise && act_ctrl_q.ctrl[0]) : tim.frame_start)
        ##1 armed_out_q;
    endsequence
    chk_ctrl_off_wr: assert property (
        ce && bus.wr && !tim.pipe_en && bus.addr == `SCB_OFF_CTRL
        |=> act_ctrl_q.ctrl == $past(bus.wdata))
        else $error("control write with pipe off not applied");
    chk_win_off_wr: assert property (
        wsz_wr && !tim.pipe_en |=> act_win_q.win_size == $past(bus.wdata))
        else $error("window write with pipe off not applied");
    chk_arm_set: assert property (s_arm |=> armed_out_q)
        else $error("window write did not arm");
    chk_disarm_evt: assert property (s_disarm |=> !armed_out_q)
        else $error("armed state not cleared");
    chk_win_cause: assert property (
        $changed(act_win_q) && $past(tim.pipe_en) |-> armed_out_q &&
        (NEWER_GEN ? ($past(vb_rise) && $past(act_ctrl_q.ctrl[0]))
        : $past(tim.frame_start)))
        else $error("window group changed without trigger");
    chk_ctrl_cause: assert property (
        $changed(act_ctrl_q) && $past(tim.pipe_en) |-> armed_out_q &&
        $past(vb_rise) && (!NEWER_GEN || $past(act_ctrl_q.ctrl[0])))
        else $error("control group changed without trigger");
    chk_sel_follow: assert property ($past(ce) |->
        {uvsel_q, ysel_q, vsel_q, hsel_q} == $past(sel_src))
        else $error("set selects do not follow control");
    chk_coef_top: assert property (
        $past(coef_rd_idx) > `SCB_COEF_LAST
        |-> coef0_word_q == 32'h0 && coef1_word_q == 32'h0)
        else $error("coefficient word beyond last index not zero");
    chk_rd_idle: assert property (
        !$past(bus.rd) |-> rdata_q == 32'h0)
        else $error("read data outside read answer cycle");
endmodule

// ### verif/scb_bank_tb.sv
// Bench: older and newer generation banks driven side by side
// Assumes rtl files and scb_bank_chk.sv are compiled before it
`timescale 1ns/1ns
`include "scb_defines.svh"
module scb_bank_tb
    import scb_pkg::*;
;
    localparam logic [159:0] WIN0 =
        {32'h00100020, 32'h03000400, 32'h111, 32'h222, 32'h333};
    logic          sys_clk = 1'b0;
    logic          rst     = 1'b1;
    logic          ce      = 1'b1;
    scb_bus_req_t  bus     = '0;
    scb_timing_t   tim     = '0;
    logic [5:0]    cidx    = 6'h00;
    wire [31:0]    rd_o [2];
    wire [3:0]     sel  [2];
    wire [31:0]    cw0  [2];
    wire [31:0]    cw1  [2];
    wire           arm  [2];
    scb_ctrl_grp_t ac   [2];
    scb_win_grp_t  aw   [2];
    int            n_fail  = 0;
    int            checked = 0;
    // Rows: address, write data, read-back value
    logic [31:0]   tab [14][3] = '{
        '{32'h00, 32'h12345678, 32'h12345678},
        '{32'h02, 32'h00100020, 32'h00100020},
        '{32'h04, 32'h111, 32'h111},
        '{32'h05, 32'h222, 32'h222},
        '{32'h06, 32'h333, 32'h333},
        '{32'h03, 32'h03000400, 32'h03000400},
        '{32'h08, 32'h3b, 32'h3b},
        '{32'h09, 32'hffff1234, 32'h1234},
        '{32'h0a, 32'h05, 32'h05},
        '{32'h0b, 32'h00010002, 32'h00010002},
        '{32'h01, 32'h1f, 32'h1f},
        '{32'h07, 32'hffffffff, 32'h0},
        '{32'h0d, 32'hffffffff, 32'h0},
        '{32'h0c, 32'hffffffff, 32'h0}};
    always #10 sys_clk = ~sys_clk;
    for (genvar g = 0; g < 2; g++)
    begin : gen_u
        scb_bank #(.NEWER_GEN(g == 1)) scb_bank_i (
            .sys_clk(sys_clk), .rst(rst), .ce(ce), .bus(bus), .tim(tim),
            .coef_rd_idx(cidx), .rdata_q(rd_o[g]), .act_ctrl_q(ac[g]),
            .act_win_q(aw[g]), .hsel_q(sel[g][0]), .vsel_q(sel[g][1]),
            .ysel_q(sel[g][2]), .uvsel_q(sel[g][3]), .coef0_word_q(cw0[g]),
            .coef1_word_q(cw1[g]), .armed_out_q(arm[g]));
    end
    task automatic cmp(string nm, logic [159:0] e, logic [159:0] s);
        checked++;
        if (s !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(logic [5:0] a, logic [31:0] d);
        @(posedge sys_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge sys_clk);
        bus.wr    <= 1'b0;
    endtask
    task automatic rd(logic [5:0] a, logic [31:0] e);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge sys_clk);
        bus.rd   <= 1'b0;
        #1;
        for (int g = 0; g < 2; g++)
            cmp("rdata", e, rd_o[g]);
    endtask
    task automatic look(logic [5:0] i);
        @(posedge sys_clk);
        cidx <= i;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic ev(bit v);
        @(posedge sys_clk);
        if (v)
            tim.vblank <= 1'b1;
        else
            tim.frame_start <= 1'b1;
        @(posedge sys_clk);
        tim.vblank      <= 1'b0;
        tim.frame_start <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        for (int g = 0; g < 2; g++)
        begin
            cmp("reset outputs", '0, {rd_o[g], sel[g], arm[g], ac[g]});
            cmp("reset window", '0, aw[g]);
            cmp("reset coef", '0, {cw0[g], cw1[g]});
        end
        @(posedge sys_clk);
        rst <= 1'b0;
        $display("reset test done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        do_reset();
        for (int i = 0; i < 14; i++)
        begin
            wr(tab[i][0][5:0], tab[i][1]);
            rd(tab[i][0][5:0], tab[i][2]);
        end
        for (int g = 0; g < 2; g++)
        begin
            cmp("act ctrl", {32'h12345678, 32'h1f}, ac[g]);
            cmp("act win", WIN0, aw[g]);
            cmp("selects", 4'hf, sel[g]);
        end
        $display("register table test done");
        look(6'h3b);
        for (int g = 0; g < 2; g++)
            cmp("coef0", 32'h1234, cw0[g]);
        look(6'h3c);
        for (int g = 0; g < 2; g++)
            cmp("coef top", 64'h0, {cw0[g], cw1[g]});
        look(6'h05);
        for (int g = 0; g < 2; g++)
            cmp("coef1", 32'h00010002, cw1[g]);
        $display("coefficient test done");
        @(posedge sys_clk);
        tim.pipe_en <= 1'b1;
        wr(`SCB_OFF_WIN_POS, 32'h99);
        wr(`SCB_OFF_COEF1_DATA, 32'h00030004);
        wr(`SCB_OFF_WIN_SIZE, 32'h03000400);
        rd(`SCB_OFF_STATUS, 32'h3);
        for (int g = 0; g < 2; g++)
            cmp("held", {32'h00100020, 32'h00010002}, {aw[g].win_pos, cw1[g]});
        ev(1'b1);
        for (int g = 0; g < 2; g++)
            cmp("vblank", {(g ? 32'h99 : 32'h00100020), 32'h00030004, g == 0},
                {aw[g].win_pos, cw1[g], arm[g]});
        ev(1'b0);
        for (int g = 0; g < 2; g++)
            cmp("frame start", {32'h99, 1'b0}, {aw[g].win_pos, arm[g]});
        $display("armed trigger test done");
        wr(`SCB_OFF_CTRL, 32'h1e);
        wr(`SCB_OFF_WIN_SIZE, 32'h03000400);
        ev(1'b1);
        wr(`SCB_OFF_WIN_POS, 32'h77);
        wr(`SCB_OFF_WIN_SIZE, 32'h03000400);
        ev(1'b1);
        for (int g = 0; g < 2; g++)
            cmp("allow off", {32'h1e, 32'h99, 1'b1},
                {ac[g].ctrl, aw[g].win_pos, arm[g]});
        $display("allow update test done");
        // Nearest-neighbour load: center tap one, pipe off commits at once
        @(posedge sys_clk);
        tim.pipe_en <= 1'b0;
        wr(`SCB_OFF_COEF0_IDX, 32'h01);
        wr(`SCB_OFF_COEF0_DATA, 32'h00010000);
        wr(`SCB_OFF_CTRL, 32'h3f);
        look(6'h01);
        for (int g = 0; g < 2; g++)
            cmp("center tap", 32'h00010000, cw0[g]);
        $display("nearest tap test done");
        // Write with clock enable low must leave the bank untouched
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(`SCB_OFF_PWR_GATE, 32'h5a);
        ce <= 1'b1;
        rd(`SCB_OFF_PWR_GATE, 32'h12345678);
        $display("clock enable test done");
        do_reset();
        wrap_up();
    end
endmodule
bind scb_bank scb_bank_chk #(.NEWER_GEN(NEWER_GEN)) scb_bank_chk_i (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .bus(bus), .tim(tim),
    .coef_rd_idx(coef_rd_idx), .rdata_q(rdata_q), .act_ctrl_q(act_ctrl_q),
    .act_win_q(act_win_q), .hsel_q(hsel_q), .vsel_q(vsel_q),
    .ysel_q(ysel_q), .uvsel_q(uvsel_q), .coef0_word_q(coef0_word_q),
    .coef1_word_q(coef1_word_q), .armed_out_q(armed_out_q));
